// [verilog/nlox_cfg.svh]
/*
  constants for the negate / complement / inclusive-or execution block.
  assumes it is included by bare name from the design and the bench.
*/
`ifndef NLOX_CFG_SVH
`define NLOX_CFG_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define NLOX_A_INSTR   8'h00
`define NLOX_A_EXT     8'h04
`define NLOX_A_EAOP    8'h08
`define NLOX_A_DREG    8'h0C
`define NLOX_A_STATE   8'h10
`define NLOX_A_RESULT  8'h14
`define NLOX_A_STATUS  8'h18
// ------------------------------------------------------------
// opcodes and fields
// ------------------------------------------------------------
`define NLOX_OP_IDLE   16'h4E71
`define NLOX_OP_CCR    16'h003C
`define NLOX_OP_SR     16'h007C
`define NLOX_HI_NEGATE_WITH_BORROW_IN   8'h40
`define NLOX_HI_NOT    8'h46
`define NLOX_HI_ORI    8'h00
`define NLOX_HI_OR     4'h8
`define NLOX_SZ_BAD    2'h3
// ------------------------------------------------------------
// state word layout and reset
// ------------------------------------------------------------
`define NLOX_F_C       0
`define NLOX_F_V       1
`define NLOX_F_Z       2
`define NLOX_F_N       3
`define NLOX_F_X       4
`define NLOX_F_SUPER   13
`define NLOX_SR_IMPL   16'hA71F
`define NLOX_SR_RST    16'h2700
// status register bits
`define NLOX_S_BUSY    0
`define NLOX_S_DONE    1
`define NLOX_S_ILL     2
`define NLOX_S_PRIV    3
`define NLOX_S_WDREG   4
`define NLOX_S_WMEM    5
`endif

// [verilog/nlox_pkg.sv]
/*
  types for the execution block.
  assumes nlox_cfg.svh is on the include path.
*/
package nlox_pkg;
  // gray along ready -> sync -> exec
  typedef enum logic [1:0] {
    ST_READY = 2'h0,
    ST_SYNC  = 2'h1,
    ST_EXEC  = 2'h3
  } nlox_state_t;

  typedef enum logic [2:0] {
    K_NONE  = 3'h0,
    K_NEGATE_WITH_BORROW_IN  = 3'h1,
    K_NOT   = 3'h2,
    K_ORI   = 3'h3,
    K_ORCCR = 3'h4,
    K_ORSR  = 3'h5,
    K_IDLE  = 3'h6,
    K_OR    = 3'h7
  } nlox_kind_t;
endpackage : nlox_pkg

// [verilog/nlox_exec.sv]
/*
  execution unit for negate-with-extend, idle, complement and the
  inclusive-or family, reached as an ahb-lite slave.
  assumes a single slave on the bus (hreadyout is the bus hready) and a
  pending-bus-cycle level from outside the clock domain.
*/
`timescale 1ns/1ps
`include "nlox_cfg.svh"
module nlox_exec (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        bus_pending,
  output logic             pc_advance,
  output logic             illegal_trap,
  output logic             privilege_trap
);
  import nlox_pkg::*;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  a_q;
  logic        take;
  logic        wr_go;
  logic [31:0] rd_mux;

  assign take  = hsel && htrans[1] && hready && (hsize == 3'h2);
  assign wr_go = wr_pend;
  // reads take one wait state so hrdata comes from a flop
  assign hreadyout = !rd_pend;
  assign hresp     = 1'b0;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      a_q     <= 8'h00;
    end else begin
      wr_pend <= take && hwrite;
      rd_pend <= take && !hwrite;
      if (take) begin
        a_q <= haddr[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // operand and state registers
  // ------------------------------------------------------------
  logic [15:0] opcode;
  logic [31:0] ext;
  logic [31:0] ea_opnd;
  logic [31:0] dreg;
  logic [15:0] sr;
  logic [31:0] result;
  logic [5:0]  status;
  nlox_state_t state;
  nlox_state_t next_state;
  logic        pend_m;
  logic        pend_s;

  // two-flop sync on the pending-bus level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_m <= 1'b0;
      pend_s <= 1'b0;
    end else begin
      pend_m <= bus_pending;
      pend_s <= pend_m;
    end
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  nlox_kind_t  kind;
  logic        legal;
  logic [1:0]  size;
  logic [2:0]  mode;
  logic [2:0]  eareg;
  logic        data_alt;
  logic        data_src;
  logic        mem_alt;
  logic        to_mem;

  assign mode  = opcode[5:3];
  assign eareg = opcode[2:0];
  // an is mode 001; pc-relative and immediate live under 111
  assign data_alt = (mode != 3'h1) &&
                    ((mode != 3'h7) || (eareg <= 3'h1));
  assign data_src = (mode != 3'h1) &&
                    ((mode != 3'h7) || (eareg <= 3'h4));
  assign mem_alt  = (mode >= 3'h2) &&
                    ((mode != 3'h7) || (eareg <= 3'h1));
  assign to_mem   = opcode[8];

  // full-word opcodes first, then the fixed high bits
  always_comb begin
    kind  = K_NONE;
    legal = 1'b0;
    size  = opcode[7:6];
    if (opcode == `NLOX_OP_IDLE) begin
      kind  = K_IDLE;
      legal = 1'b1;
    end else if (opcode == `NLOX_OP_CCR) begin
      kind  = K_ORCCR;
      legal = 1'b1;
    end else if (opcode == `NLOX_OP_SR) begin
      kind  = K_ORSR;
      legal = 1'b1;
    end else if (opcode[15:8] == `NLOX_HI_NEGATE_WITH_BORROW_IN) begin
      kind  = K_NEGATE_WITH_BORROW_IN;
      legal = data_alt && (size != `NLOX_SZ_BAD);
    end else if (opcode[15:8] == `NLOX_HI_NOT) begin
      kind  = K_NOT;
      legal = data_alt && (size != `NLOX_SZ_BAD);
    end else if (opcode[15:8] == `NLOX_HI_ORI) begin
      kind  = K_ORI;
      legal = data_alt && (size != `NLOX_SZ_BAD);
    end else if (opcode[15:12] == `NLOX_HI_OR) begin
      kind  = K_OR;
      size  = opcode[7:6] == `NLOX_SZ_BAD ? `NLOX_SZ_BAD : opcode[7:6];
      // opmode x11 belongs to other opcodes
      legal = (size != `NLOX_SZ_BAD) &&
              (to_mem ? mem_alt : data_src);
    end
  end

  // ------------------------------------------------------------
  // datapath: operands left-aligned so one adder serves all widths
  // ------------------------------------------------------------
  logic [4:0]  sh;
  logic [31:0] wmask;
  logic [31:0] amask;
  logic [31:0] d_al;
  logic [31:0] s_al;
  logic [31:0] x_al;
  logic [32:0] diff;
  logic [31:0] r_al;
  logic [31:0] r_out;

  always_comb begin
    case (size)
      2'h0:    sh = 5'd24;
      2'h1:    sh = 5'd16;
      default: sh = 5'd0;
    endcase
  end

  assign amask = 32'hFFFFFFFF << sh;
  assign wmask = 32'hFFFFFFFF >> sh;
  assign d_al  = ea_opnd << sh;
  // immediate low byte / word / long falls out of the shift
  assign s_al  = (kind == K_ORI ? ext : dreg) << sh;
  assign x_al  = {31'h0, sr[`NLOX_F_X]} << sh;
  assign diff  = {1'b0, 32'h0} - {1'b0, d_al} - {1'b0, x_al};

  always_comb begin
    case (kind)
      K_NEGATE_WITH_BORROW_IN:  r_al = diff[31:0];
      K_NOT:   r_al = ~d_al & amask;
      default: r_al = (d_al | s_al) & amask;
    endcase
  end
  assign r_out = r_al >> sh;

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  logic start;
  assign start = wr_go && (a_q == `NLOX_A_INSTR) && (state == ST_READY);

  always_comb begin
    next_state = state;
    case (state)
      ST_READY: begin
        if (start) begin
          next_state = (hwdata[15:0] == `NLOX_OP_IDLE) ? ST_SYNC : ST_EXEC;
        end
      end
      // hold until the outside bus has drained
      ST_SYNC: begin
        if (!pend_s) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC:  next_state = ST_READY;
      default:  next_state = ST_READY;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_READY;
    end else begin
      state <= next_state;
    end
  end

  logic exec;
  logic trap_priv;
  logic dst_dreg;
  assign exec      = (state == ST_EXEC);
  assign trap_priv = (kind == K_ORSR) && !sr[`NLOX_F_SUPER];
  // negate/complement/ori with mode 000, or or into dn, go to the register
  assign dst_dreg  = (kind == K_OR) ? !to_mem : (mode == 3'h0);

  // trap and completion pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_advance     <= 1'b0;
      illegal_trap   <= 1'b0;
      privilege_trap <= 1'b0;
    end else begin
      pc_advance     <= exec && legal && !trap_priv;
      illegal_trap   <= exec && !legal;
      privilege_trap <= exec && legal && trap_priv;
    end
  end

  // ------------------------------------------------------------
  // state word: execution beats a same-cycle software write
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr <= `NLOX_SR_RST;
    end else if (exec && legal) begin
      case (kind)
        K_NEGATE_WITH_BORROW_IN: begin
          sr[`NLOX_F_C] <= diff[32];
          sr[`NLOX_F_X] <= diff[32];
          sr[`NLOX_F_N] <= r_al[31];
          sr[`NLOX_F_V] <= d_al[31] & r_al[31];
          if (r_al != 32'h0) begin
            sr[`NLOX_F_Z] <= 1'b0;
          end
        end
        K_NOT, K_ORI, K_OR: begin
          sr[`NLOX_F_N] <= r_al[31];
          sr[`NLOX_F_Z] <= (r_al == 32'h0);
          sr[`NLOX_F_V] <= 1'b0;
          sr[`NLOX_F_C] <= 1'b0;
        end
        // low byte of the state word, bits above x unimplemented
        K_ORCCR: sr[4:0] <= sr[4:0] | ext[4:0];
        K_ORSR: begin
          if (!trap_priv) begin
            sr <= (sr | ext[15:0]) & `NLOX_SR_IMPL;
          end
        end
        default: sr <= sr;
      endcase
    end else if (wr_go && a_q == `NLOX_A_STATE) begin
      sr <= hwdata[15:0] & `NLOX_SR_IMPL;
    end
  end

  // ------------------------------------------------------------
  // operands and result; write-back merges only the sized slice
  // ------------------------------------------------------------
  logic wb;
  assign wb = exec && legal &&
              (kind == K_NEGATE_WITH_BORROW_IN || kind == K_NOT || kind == K_ORI ||
               kind == K_OR);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opcode <= 16'h0000;
      ext    <= 32'h00000000;
    end else if (wr_go) begin
      if (a_q == `NLOX_A_INSTR && state == ST_READY) begin
        opcode <= hwdata[15:0];
      end
      if (a_q == `NLOX_A_EXT) begin
        ext <= hwdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ea_opnd <= 32'h00000000;
    end else if (wb && !(kind == K_OR && !to_mem)) begin
      ea_opnd <= (ea_opnd & ~wmask) | r_out;
    end else if (wr_go && a_q == `NLOX_A_EAOP) begin
      ea_opnd <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dreg <= 32'h00000000;
    end else if (wb && kind == K_OR && !to_mem) begin
      dreg <= (dreg & ~wmask) | r_out;
    end else if (wr_go && a_q == `NLOX_A_DREG) begin
      dreg <= hwdata;
    end
  end

  // clear mask of a status write, zero when no write lands this cycle
  logic [3:1] w1c;
  assign w1c = (wr_go && a_q == `NLOX_A_STATUS) ? hwdata[3:1] : 3'h0;

  // result and sticky status; a completing set beats a w1c clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= 32'h00000000;
      status <= 6'h00;
    end else begin
      if (wb) begin
        result <= r_out;
      end
      status[3:1] <= status[3:1] & ~w1c;
      // a clear in the completing cycle still lands unless the set fires
      if (exec) begin
        status[`NLOX_S_DONE]  <= 1'b1;
        status[`NLOX_S_ILL]   <= !legal |
                                 (status[`NLOX_S_ILL] & !w1c[`NLOX_S_ILL]);
        status[`NLOX_S_PRIV]  <= (legal & trap_priv) |
                                 (status[`NLOX_S_PRIV] & !w1c[`NLOX_S_PRIV]);
        status[`NLOX_S_WDREG] <= wb && dst_dreg;
        status[`NLOX_S_WMEM]  <= wb && !dst_dreg;
      end
      status[`NLOX_S_BUSY] <= (next_state != ST_READY);
    end
  end

  // read data mux, loaded during the wait state
  always_comb begin
    case (a_q)
      `NLOX_A_INSTR:  rd_mux = {16'h0000, opcode};
      `NLOX_A_EXT:    rd_mux = ext;
      `NLOX_A_EAOP:   rd_mux = ea_opnd;
      `NLOX_A_DREG:   rd_mux = dreg;
      `NLOX_A_STATE:  rd_mux = {16'h0000, sr};
      `NLOX_A_RESULT: rd_mux = result;
      `NLOX_A_STATUS: rd_mux = {26'h0000000, status};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend) begin
      hrdata <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_go(nlox_kind_t k);
    exec && legal && kind == k;
  endsequence
  sequence s_logic;
    exec && legal && (kind == K_NOT || kind == K_ORI || kind == K_OR);
  endsequence

  property p_negate_with_borrow_in_xc;
    s_go(K_NEGATE_WITH_BORROW_IN) |=> sr[`NLOX_F_X] == sr[`NLOX_F_C]
                     && sr[`NLOX_F_C] == $past(diff[32]);
  endproperty
  a_negate_with_borrow_in_xc: assert property (p_negate_with_borrow_in_xc)
    else $error("negate carry or extend wrong");

  property p_negate_with_borrow_in_z;
    s_go(K_NEGATE_WITH_BORROW_IN) |=> sr[`NLOX_F_Z] ==
      ($past(sr[`NLOX_F_Z]) && $past(r_al) == 32'h0);
  endproperty
  a_negate_with_borrow_in_z: assert property (p_negate_with_borrow_in_z)
    else $error("negate zero flag wrong");

  property p_size_bad;
    exec && kind != K_OR && kind != K_IDLE && kind != K_NONE &&
      opcode[7:6] == `NLOX_SZ_BAD
      |=> illegal_trap && !pc_advance;
  endproperty
  a_size_bad: assert property (p_size_bad)
    else $error("size 11 accepted");

  property p_not;
    s_go(K_NOT) |=> result == (~$past(ea_opnd) & $past(wmask));
  endproperty
  a_not: assert property (p_not)
    else $error("complement result wrong");

  property p_logic_flags;
    s_logic |=> !sr[`NLOX_F_V] && !sr[`NLOX_F_C]
                && $stable(sr[`NLOX_F_X]);
  endproperty
  a_logic_flags: assert property (p_logic_flags)
    else $error("logic flags wrong");

  property p_idle_wait;
    state == ST_SYNC && pend_s |=> state == ST_SYNC ##1 !pc_advance;
  endproperty
  a_idle_wait: assert property (p_idle_wait)
    else $error("idle ran with bus pending");

  property p_idle_flags;
    s_go(K_IDLE) |=> pc_advance && $stable(sr) && !status[`NLOX_S_WMEM];
  endproperty
  a_idle_flags: assert property (p_idle_flags)
    else $error("idle changed state");

  property p_ccr;
    s_go(K_ORCCR) |=> sr[4:0] == ($past(sr[4:0]) | $past(ext[4:0]));
  endproperty
  a_ccr: assert property (p_ccr)
    else $error("flag byte or wrong");

  property p_sr_priv;
    s_go(K_ORSR) ##0 !sr[`NLOX_F_SUPER] |=> privilege_trap && $stable(sr);
  endproperty
  a_sr_priv: assert property (p_sr_priv)
    else $error("user state word write not trapped");

  property p_or_an;
    exec && kind == K_OR && mode == 3'h1 |=> illegal_trap;
  endproperty
  a_or_an: assert property (p_or_an)
    else $error("address register used by or");
endmodule : nlox_exec

// [bench/nlox_exec_tb_top.sv]
/*
  self-checking bench for the execution block: ahb-lite tasks, a row
  table run by one loop, then idle sync, busy refusal and a reset while idle.
  assumes nlox_cfg.svh on the include path and one slave on the bus.
*/
`timescale 1ns/1ps
`include "nlox_cfg.svh"
module nlox_exec_tb_top;
  typedef struct {
    logic [15:0] op;
    logic [31:0] ext;
    logic [31:0] ea;
    logic [31:0] dr;
    logic [15:0] st;
    logic [31:0] x_ea;
    logic [31:0] x_dr;
    logic [15:0] x_st;
    logic [3:0]  x_flg;
    logic [2:0]  x_pls;
  } nlox_row_t;

  logic        hclk, hresetn, hsel, hwrite, bus_pending;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, pc_advance, illegal_trap, privilege_trap;
  int          fail_count, checks_done, n_pc, n_ill, n_priv, p0;
  nlox_row_t   rows [0:13];
  nlox_row_t   r;
  logic [15:0] bad_ops [0:8];

  // ----------------------------------------------------------
  // clock, design, pulse counters
  // ----------------------------------------------------------
  initial hclk = 1'b0;
  always #50 hclk = ~hclk;

  nlox_exec DUT (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .hsel           (hsel),
    .haddr          (haddr),
    .htrans         (htrans),
    .hwrite         (hwrite),
    .hsize          (hsize),
    .hwdata         (hwdata),
    .hready         (hreadyout),
    .hreadyout      (hreadyout),
    .hresp          (hresp),
    .hrdata         (hrdata),
    .bus_pending    (bus_pending),
    .pc_advance     (pc_advance),
    .illegal_trap   (illegal_trap),
    .privilege_trap (privilege_trap)
  );

  // count high cycles, so a pulse that lingers shows as a second event
  always @(posedge hclk) begin
    if (pc_advance === 1'b1) n_pc <= n_pc + 1;
    if (illegal_trap === 1'b1) n_ill <= n_ill + 1;
    if (privilege_trap === 1'b1) n_priv <= n_priv + 1;
  end

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk

  // entered just after a rising edge; ready seen at negedge is what the
  // next rising edge samples, so nothing races the combinational ready
  task xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "hresp");
    @(posedge hclk);
  endtask : xfer

  task wait_idle();
    int n;
    n = 0;
    do begin
      xfer(`NLOX_A_STATUS, 1'b0, 32'h0);
      n++;
    end while (rd[`NLOX_S_BUSY] !== 1'b0 && n < 60);
    chk({31'h0, rd[`NLOX_S_BUSY]}, 32'h0, "busy stuck");
  endtask : wait_idle

  task run_row(input nlox_row_t q);
    int i0, v0;
    p0 = n_pc;
    i0 = n_ill;
    v0 = n_priv;
    xfer(`NLOX_A_STATUS, 1'b1, 32'h0000000E);
    xfer(`NLOX_A_EXT, 1'b1, q.ext);
    xfer(`NLOX_A_EAOP, 1'b1, q.ea);
    xfer(`NLOX_A_DREG, 1'b1, q.dr);
    xfer(`NLOX_A_STATE, 1'b1, {16'h0, q.st});
    xfer(`NLOX_A_INSTR, 1'b1, {16'h0, q.op});
    wait_idle();
    xfer(`NLOX_A_EAOP, 1'b0, 32'h0);
    chk(rd, q.x_ea, "operand");
    xfer(`NLOX_A_DREG, 1'b0, 32'h0);
    chk(rd, q.x_dr, "data reg");
    xfer(`NLOX_A_STATE, 1'b0, 32'h0);
    chk({16'h0, rd[15:0]}, {16'h0, q.x_st}, "state");
    chk({16'h0, rd[15:0]}, {16'h0, q.x_st}, "sr or");
    xfer(`NLOX_A_STATUS, 1'b0, 32'h0);
    chk({28'h0, rd[5:2]}, {28'h0, q.x_flg}, "status");
    chk(n_pc - p0, {31'h0, q.x_pls[2]}, "advance");
    chk(n_ill - i0, {31'h0, q.x_pls[1]}, "illegal");
    chk(n_priv - v0, {31'h0, q.x_pls[0]}, "privilege");
  endtask : run_row

  task print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------
  // watchdog: a few hundred cycles per row at most, with wide margin
  // ----------------------------------------------------------
  initial begin
    repeat (30000) @(posedge hclk);
    fail_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    print_verdict();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, bus_pending} = 4'h0;
    {haddr, hwdata, htrans, hsize} = 69'h0;
    {fail_count, checks_done, n_pc, n_ill, n_priv} = '0;
    // negate with extend: byte borrow, word zero keeps z, long overflow
    rows[0]  = '{16'h4000, 0, 32'h1, 0, 16'h2714, 32'hFE, 0, 16'h2719, 4, 4};
    rows[1]  = '{16'h4050, 0, 32'hABCD0000, 0, 16'h2704,
                 32'hABCD0000, 0, 16'h2704, 8, 4};
    rows[2]  = '{16'h4090, 0, 32'h80000000, 0, 16'h2700,
                 32'h80000000, 0, 16'h271B, 8, 4};
    // complement and immediate or, upper ext bits must not leak in byte
    rows[3]  = '{16'h4600, 0, 32'h123456FF, 0, 16'h2713,
                 32'h12345600, 0, 16'h2714, 4, 4};
    rows[4]  = '{16'h4650, 0, 32'hF0F, 0, 16'h2700, 32'hF0F0, 0, 16'h2708, 8, 4};
    rows[5]  = '{16'h0090, 32'h10000, 1, 0, 16'h2717, 32'h10001, 0,
                 16'h2710, 8, 4};
    rows[6]  = '{16'h0000, 32'hFF80, 32'hFFFFFF00, 0, 16'h2700,
                 32'hFFFFFF80, 0, 16'h2708, 4, 4};
    // or both directions, pc-relative source
    rows[7]  = '{16'h8010, 0, 32'hF, 32'h11223340, 16'h2700,
                 32'hF, 32'h1122334F, 16'h2700, 4, 4};
    rows[8]  = '{16'h8150, 0, 32'h12340001, 32'h8000, 16'h2700,
                 32'h12348001, 32'h8000, 16'h2708, 8, 4};
    rows[9]  = '{16'h80BA, 0, 0, 0, 16'h2700, 0, 0, 16'h2704, 4, 4};
    // flag byte, state word in supervisor and in user state
    rows[10] = '{16'h003C, 32'hFF15, 0, 0, 16'h2702, 0, 0, 16'h2717, 0, 4};
    rows[11] = '{16'h007C, 32'hFFFF, 0, 0, 16'h2700, 0, 0, 16'hA71F, 0, 4};
    rows[12] = '{16'h007C, 32'hFFFF, 0, 0, 16'h0004, 0, 0, 16'h0004, 2, 1};
    // word immediate or into an absolute destination
    rows[13] = '{16'h0078, 32'h12340080, 32'hFFFF0001, 0, 16'h2700,
                 32'hFFFF0081, 0, 16'h2700, 8, 4};
    // size 11, address register, immediate dest, dn-as-ea dest, bad opmode
    bad_ops = '{16'h40C0, 16'h00C0, 16'h4608, 16'h00BC, 16'h8100,
                16'h8008, 16'h80C0, 16'h407A, 16'hFFFF};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 14; i++) run_row(rows[i]);
    foreach (bad_ops[i]) begin
      r = '{bad_ops[i], 0, 32'h55, 32'h66, 16'h2700,
            32'h55, 32'h66, 16'h2700, 1, 2};
      run_row(r);
    end
    // idle held while the bus is busy; a new opcode meanwhile is refused
    xfer(`NLOX_A_STATE, 1'b1, 32'h271F);
    xfer(`NLOX_A_EAOP, 1'b1, 32'h5A);
    p0 = n_pc;
    bus_pending <= 1'b1;
    xfer(`NLOX_A_INSTR, 1'b1, {16'h0, `NLOX_OP_IDLE});
    repeat (8) @(posedge hclk);
    xfer(`NLOX_A_STATUS, 1'b0, 32'h0);
    chk({31'h0, rd[`NLOX_S_BUSY]}, 32'h1, "idle held");
    chk(n_pc - p0, 0, "early advance");
    xfer(`NLOX_A_INSTR, 1'b1, 32'h4600);
    bus_pending <= 1'b0;
    wait_idle();
    chk(n_pc - p0, 1, "idle advance");
    xfer(`NLOX_A_STATE, 1'b0, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h271F, "idle flags");
    xfer(`NLOX_A_EAOP, 1'b0, 32'h0);
    chk(rd, 32'h5A, "busy write refused");
    // reset with the block idle, then reset values and an unmapped place
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(8'h40, 1'b1, 32'hFFFFFFFF);
    xfer(8'h40, 1'b0, 32'h0);
    chk(rd, 32'h0, "unmapped");
    xfer(`NLOX_A_STATE, 1'b0, 32'h0);
    chk({16'h0, rd[15:0]}, {16'h0, `NLOX_SR_RST}, "state reset");
    xfer(`NLOX_A_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0, "status reset");
    xfer(`NLOX_A_RESULT, 1'b0, 32'h0);
    chk(rd, 32'h0, "result reset");
    print_verdict();
  end
endmodule : nlox_exec_tb_top
